/* core/gab_status.v */
// Contract
// - latch eoi line into minor readback bit 7 on each accepted byte
// - chip reset command clears latched eoi; otherwise held until next byte
// - minor talker disable blocks minor talk address comparison; secondary only when listener disable is also set
// - minor listener disable blocks minor listen address comparison; secondary only when talker disable is also set
// - minor readback bits 4 to 0 hold the five-bit minor address
// - secondary address is minor field plus hex 60
// - minor talk address is minor field plus hex 40
// - minor listen address is minor field plus hex 20
// - extended single mode uses secondary; dual primary uses minor primary
// - controller-in-charge bit is one unless controller idle or addr-idle
// - attention bit shows bus attention level; zero means asserted
// - serial poll mode flag enables talker for serial poll
// - serial poll enable in accept data state sets the flag
// - serial poll disable, power-on or interface clear clears the flag
`timescale 1ns/1ps
`include "gab_defines.vh"

module gab_status (
    // clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // register port
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // gpib side
    input  wire [7:0] bus_data,
    input  wire       bus_eoi,
    input  wire       bus_atn_n,
    input  wire       bus_ifc,
    input  wire       byte_taken,
    input  wire       accept_data,
    // controller state
    input  wire       ctrl_idle,
    input  wire       ctrl_addr_idle,
    // addressing mode
    input  wire [1:0] addr_mode,
    // address recognition
    output reg        secondary_match,
    output reg        minor_talk_match,
    output reg        minor_listen_match,
    // poll and interrupt
    output wire       serial_poll_talk_en,
    output wire       irq
);

    // minor address register: disables and five address bits
    reg  [6:0] minor_q;
    reg        eoi_q;
    reg        serial_poll_mode_flag_q;
    reg        atn_meta_q;
    reg        atn_sync_q;
    reg  [2:0] irq_stat_q;
    reg  [2:0] irq_mask_q;

    wire       minor_talker_disable;
    wire       minor_listener_disable;
    wire [4:0] minor_field;
    wire [7:0] sec_addr;
    wire [7:0] talk_addr;
    wire [7:0] listen_addr;
    wire       aux_wr;
    wire       pon;
    wire       chip_rst;
    wire       cmd_byte;
    wire       spe_seen;
    wire       spd_seen;
    wire       ext_single;
    wire       dual_mode;
    wire       sec_hit;
    wire       talk_hit;
    wire       listen_hit;
    wire [7:0] minor_readback;
    wire [7:0] state_readback;
    wire [2:0] irq_events;
    wire [2:0] irq_clear;
    reg  [7:0] rd_mux;

    assign minor_talker_disable   = minor_q[`GAB_BIT_DT];
    assign minor_listener_disable = minor_q[`GAB_BIT_DL];
    assign minor_field            = minor_q[4:0];

    assign sec_addr    = `GAB_SEC_BASE + {3'h0, minor_field};
    assign talk_addr   = `GAB_TALK_BASE + {3'h0, minor_field};
    assign listen_addr = `GAB_LISTEN_BASE + {3'h0, minor_field};

    assign aux_wr   = reg_wr && (reg_addr == `GAB_OFF_AUX);
    assign pon      = aux_wr && (reg_wdata == `GAB_AUX_PON);
    assign chip_rst = aux_wr && (reg_wdata == `GAB_AUX_CHIP_RST);

    // commands are bytes taken while attention is asserted
    assign cmd_byte = byte_taken && !bus_atn_n;
    assign spe_seen = cmd_byte && accept_data
                      && (bus_data == `GAB_CMD_SPE);
    assign spd_seen = cmd_byte && accept_data
                      && (bus_data == `GAB_CMD_SPD);

    assign ext_single = (addr_mode == `GAB_MODE_EXT_SINGLE)
                        || (addr_mode == `GAB_MODE_DUAL_EXT);
    assign dual_mode  = (addr_mode == `GAB_MODE_DUAL)
                        || (addr_mode == `GAB_MODE_DUAL_EXT);

    // a secondary byte is matched if either minor role remains enabled
    assign sec_hit    = cmd_byte && ext_single && (bus_data == sec_addr)
                        && !(minor_talker_disable && minor_listener_disable);
    assign talk_hit   = cmd_byte && dual_mode && (bus_data == talk_addr)
                        && !minor_talker_disable;
    assign listen_hit = cmd_byte && dual_mode && (bus_data == listen_addr)
                        && !minor_listener_disable;

    // match pulses are registered so they line up with the readback
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            secondary_match    <= 1'b0;
            minor_talk_match   <= 1'b0;
            minor_listen_match <= 1'b0;
        end else begin
            secondary_match    <= sec_hit;
            minor_talk_match   <= talk_hit;
            minor_listen_match <= listen_hit;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            minor_q <= `GAB_RST_MINOR;
        end else if (reg_wr && (reg_addr == `GAB_OFF_ADDR)
                     && reg_wdata[`GAB_BIT_SELECT]) begin
            minor_q <= reg_wdata[6:0];
        end
    end

    // byte arrival wins over chip reset so a new end flag is never lost
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eoi_q <= 1'b0;
        end else if (byte_taken) begin
            eoi_q <= bus_eoi;
        end else if (chip_rst) begin
            eoi_q <= 1'b0;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_poll_mode_flag_q <= 1'b0;
        end else if (pon || bus_ifc || spd_seen) begin
            serial_poll_mode_flag_q <= 1'b0;
        end else if (spe_seen) begin
            serial_poll_mode_flag_q <= 1'b1;
        end
    end

    assign serial_poll_talk_en = serial_poll_mode_flag_q;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            atn_meta_q <= 1'b1;
            atn_sync_q <= 1'b1;
        end else begin
            atn_meta_q <= bus_atn_n;
            atn_sync_q <= atn_meta_q;
        end
    end

    assign minor_readback = {eoi_q, minor_q};

    assign state_readback = {!(ctrl_idle || ctrl_addr_idle),
                             atn_sync_q, serial_poll_mode_flag_q, 5'h00};

    assign irq_events = {sec_hit || talk_hit || listen_hit,
                         spe_seen,
                         byte_taken && bus_eoi};

    assign irq_clear = (reg_wr && (reg_addr == `GAB_OFF_IRQ_STAT))
                       ? reg_wdata[2:0] : 3'h0;

    // set beats write-one-to-clear in the same cycle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_events;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask_q <= `GAB_RST_MASK;
        end else if (reg_wr && (reg_addr == `GAB_OFF_IRQ_MASK)) begin
            irq_mask_q <= reg_wdata[2:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    always @* begin
        case (reg_addr)
            `GAB_OFF_ADDR:     rd_mux = minor_readback;
            `GAB_OFF_STATE:    rd_mux = state_readback;
            `GAB_OFF_IRQ_STAT: rd_mux = {5'h00, irq_stat_q};
            `GAB_OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask_q};
            default:           rd_mux = 8'h00;
        endcase
    end

    // read sample
    // read data stand for one cycle only, zero otherwise
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // gab_status

/* core/gab_defines.vh */
`ifndef GAB_DEFINES_VH
`define GAB_DEFINES_VH

// register offsets on the plain port
`define GAB_OFF_ADDR      3'h0
`define GAB_OFF_STATE     3'h1
`define GAB_OFF_AUX       3'h2
`define GAB_OFF_IRQ_STAT  3'h3
`define GAB_OFF_IRQ_MASK  3'h4

// address write / minor readback fields
`define GAB_BIT_SELECT    7
`define GAB_BIT_EOI       7
`define GAB_BIT_DT        6
`define GAB_BIT_DL        5

// address state readback fields
`define GAB_BIT_CIC       7
`define GAB_BIT_ATN       6
`define GAB_BIT_SERIAL_POLL_MODE_FLAG      5

// bus byte offsets for address recognition
`define GAB_SEC_BASE      8'h60
`define GAB_TALK_BASE     8'h40
`define GAB_LISTEN_BASE   8'h20

// serial poll universal commands
`define GAB_CMD_SPE       8'h18
`define GAB_CMD_SPD       8'h19

// auxiliary command codes
`define GAB_AUX_PON       8'h00
`define GAB_AUX_CHIP_RST  8'h02

// addressing modes
`define GAB_MODE_EXT_SINGLE 2'h1
`define GAB_MODE_DUAL       2'h2
`define GAB_MODE_DUAL_EXT   2'h3

// interrupt status bits
`define GAB_IRQ_EOI       0
`define GAB_IRQ_SERIAL_POLL_MODE_FLAG      1
`define GAB_IRQ_MATCH     2
`define GAB_IRQ_W         3

// reset values
`define GAB_RST_MINOR     7'h00
`define GAB_RST_MASK      3'h0

`endif

/* bench/gab_status_props.sv */
`timescale 1ns/1ps
module gab_status_props (
    input wire logic       clk, sys_rst, reg_wr, reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata, bus_data,
    input wire logic       bus_eoi, bus_atn_n, bus_ifc, byte_taken,
    input wire logic       accept_data, ctrl_idle, ctrl_addr_idle,
    input wire logic [1:0] addr_mode,
    input wire logic       secondary_match, minor_talk_match,
    input wire logic       minor_listen_match, serial_poll_talk_en, irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire cmd = byte_taken && !bus_atn_n;
    chk_talk_match: assert property (
        minor_talk_match |-> $past(cmd && bus_data[7:5] == 3'h2))
        else $error("talk match without talk byte");
    chk_listen_match: assert property (
        minor_listen_match |-> $past(cmd && bus_data[7:5] == 3'h1))
        else $error("listen match without listen byte");
    chk_sec_match: assert property (
        secondary_match |-> $past(cmd && bus_data[7:5] == 3'h3))
        else $error("secondary match without byte");
    chk_sec_mode: assert property (
        secondary_match |-> $past(addr_mode[0]))
        else $error("secondary match in wrong mode");
    chk_minor_mode: assert property (
        minor_talk_match || minor_listen_match |-> $past(addr_mode[1]))
        else $error("minor match in wrong mode");
    chk_serial_poll_mode_flag_set: assert property (
        cmd && accept_data && bus_data == 8'h18 && !bus_ifc && !reg_wr
        |=> serial_poll_talk_en) else $error("poll mode not set");
    chk_serial_poll_mode_flag_ifc: assert property (
        bus_ifc |=> !serial_poll_talk_en) else $error("poll mode kept");
    chk_rd_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
    chk_cic_read: assert property (
        reg_rd && reg_addr == 3'h1
        |=> reg_rdata[7] == $past(!(ctrl_idle || ctrl_addr_idle)))
        else $error("controller bit wrong");
    chk_serial_poll_mode_flag_read: assert property (
        reg_rd && reg_addr == 3'h1
        |=> reg_rdata[5] == $past(serial_poll_talk_en))
        else $error("poll mode bit wrong");
    chk_eoi_latch: assert property (
        byte_taken ##1 !byte_taken && !reg_wr ##1
        reg_rd && reg_addr == 3'h0 && !byte_taken
        |=> reg_rdata[7] == $past(bus_eoi, 3)) else $error("eoi bit wrong");
endmodule // gab_status_props
bind gab_status gab_status_props chk (.*);

/* bench/gab_gpib_model.sv */
`timescale 1ns/1ps
module gab_gpib_model (
    // acceptor side of the bus
    input  wire logic  clk,
    output logic [7:0] bus_data,
    output logic       bus_eoi,
    output logic       byte_taken,
    output logic       accept_data
);
    initial begin
        bus_data = 8'h00;
        bus_eoi = 1'b0;
        byte_taken = 1'b0;
        accept_data = 1'b0;
    end
    // released data lines show the inverse and the other lines drop to zero, so stale data never looks valid
    task automatic send(input logic [7:0] d, input logic e, input logic a,
                        input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        bus_data <= d;
        bus_eoi <= e;
        accept_data <= a;
        byte_taken <= 1'b1;
        @(posedge clk);
        bus_data <= ~d;
        bus_eoi <= 1'b0;
        accept_data <= 1'b0;
        byte_taken <= 1'b0;
    endtask
endmodule // gab_gpib_model

/* bench/gab_status_test.sv */
`timescale 1ns/1ps
module gab_status_test;
    logic       clk, sys_rst, reg_wr, reg_rd, irq, bus_eoi, bus_atn_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, bus_data;
    logic       bus_ifc, byte_taken, accept_data, ctrl_idle, ctrl_addr_idle;
    logic       secondary_match, minor_talk_match, minor_listen_match;
    logic       serial_poll_talk_en;
    logic [1:0] addr_mode;
    int         num_errors = 0;
    int         comparisons = 0;
    // counts match pulses so the three match outputs are checked too
    int         match_cnt = 0;
    // mode, minor write, bus byte, expected match status
    logic [25:0] tbl [11] = '{26'h3_85_45_04, 26'h3_85_25_04,
        26'h3_85_65_04, 26'h3_85_46_00, 26'h3_C5_45_00, 26'h3_C5_25_04,
        26'h3_A5_25_00, 26'h3_A5_45_04, 26'h3_E5_65_00, 26'h1_85_45_00,
        26'h2_85_65_00};
    gab_status uut (.*);
    gab_gpib_model bfm (.clk, .bus_data, .bus_eoi, .byte_taken, .accept_data);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask
    always @(posedge clk) begin
        if (secondary_match || minor_talk_match || minor_listen_match)
            match_cnt <= match_cnt + 1;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        {sys_rst, ctrl_idle, bus_atn_n} = 3'h7;
        {reg_wr, reg_rd, bus_ifc, ctrl_addr_idle} = 4'h0;
        {reg_addr, reg_wdata, addr_mode} = 13'h0000;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        bus_atn_n <= 1'b0;
        rd(3'h7, 8'h00);
        wr(3'h0, 8'h1A);
        rd(3'h0, 8'h00);
        foreach (tbl[i]) begin
            addr_mode <= tbl[i][25:24];
            wr(3'h0, tbl[i][23:16]);
            rd(3'h0, {1'b0, tbl[i][22:16]});
            bfm.send(tbl[i][15:8], 1'b0, 1'b0, i % 3);
            rd(3'h3, tbl[i][7:0]);
            wr(3'h3, 8'h07);
        end
        bus_atn_n <= 1'b1;
        wr(3'h4, 8'h01);
        bfm.send(8'h55, 1'b1, 1'b0, 2);
        rd(3'h0, 8'h85);
        chk("irq", 8'h01, {7'h00, irq});
        wr(3'h3, 8'h01);
        #1 chk("irq", 8'h00, {7'h00, irq});
        wr(3'h4, 8'h00);
        bfm.send(8'hAA, 1'b1, 1'b0, 0);
        rd(3'h3, 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
        bfm.send(8'h55, 1'b0, 1'b0, 0);
        rd(3'h0, 8'h05);
        bfm.send(8'h55, 1'b1, 1'b0, 0);
        wr(3'h2, 8'h02);
        rd(3'h0, 8'h05);
        bus_atn_n <= 1'b0;
        bfm.send(8'h18, 1'b0, 1'b1, 0);
        rd(3'h1, 8'h20);
        chk("poll_en", 8'h01, {7'h00, serial_poll_talk_en});
        bfm.send(8'h19, 1'b0, 1'b1, 0);
        rd(3'h1, 8'h00);
        bfm.send(8'h18, 1'b0, 1'b0, 0);
        rd(3'h1, 8'h00);
        bfm.send(8'h18, 1'b0, 1'b1, 0);
        wr(3'h2, 8'h00);
        rd(3'h1, 8'h00);
        bfm.send(8'h18, 1'b0, 1'b1, 0);
        bus_ifc <= 1'b1;
        @(posedge clk);
        bus_ifc <= 1'b0;
        rd(3'h1, 8'h00);
        ctrl_idle <= 1'b0;
        rd(3'h1, 8'h80);
        ctrl_addr_idle <= 1'b1;
        bus_atn_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(3'h1, 8'h40);
        chk("match_count", 8'h05, match_cnt[7:0]);
        print_verdict();
    end
endmodule // gab_status_test
